// ---- core/eqfcb_pkg.sv ----
/*
  Constants for the equalizer coefficient bank: register offsets, field
  layout, reset values and tap positions.
  Assumes a byte-addressed register port with 16-bit register data.
*/
package eqfcb_pkg;
   // Address and data widths of the register port.
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   // Register offsets as printed; they are not all multiples of four.
   localparam logic [11:0] CHAN_A_TAP8_COEF_OFF = 12'h429;
   localparam logic [11:0] CHAN_B_TAP0_COEF_OFF = 12'h448;
   localparam logic [11:0] CHAN_B_TAP1_COEF_OFF = 12'h44A;
   localparam logic [11:0] CHAN_B_TAP2_COEF_OFF = 12'h44C;
   localparam logic [11:0] CHAN_B_TAP3_COEF_OFF = 12'h44E;
   // Number of registers held here.
   localparam int NUM_REGS = 5;
   localparam int IDX_W = 3;
   // Outer taps carry a 12-bit signed field in the low bits.
   localparam int OUTER_COEF_W = 12;
   localparam int OUTER_COEF_MSB = 11;
   // The centre tap is wider; its bank output is tied to zero and left unused.
   localparam int CENTRE_COEF_W = 18;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] UNMAPPED_READ = 16'h0000;
   // Register slot numbers inside the bank.
   localparam logic [2:0] SLOT_A8 = 3'h0;
   localparam logic [2:0] SLOT_B0 = 3'h1;
   localparam logic [2:0] SLOT_B1 = 3'h2;
   localparam logic [2:0] SLOT_B2 = 3'h3;
   localparam logic [2:0] SLOT_B3 = 3'h4;
   localparam logic [2:0] SLOT_NONE = 3'h7;
endpackage

// ---- core/eqfcb_sync.sv ----
/*
  Two flip-flop reset release synchroniser.
  Assumes arst_n may fall at any time and rises unrelated to clk.
*/
`timescale 1ns/100ps
module eqfcb_sync (
   input wire logic clk,
   input wire logic arst_n,
   output logic rst_n
);
   typedef struct packed {
      logic meta;
      logic rel;
   } eqfcb_sync_t;
   eqfcb_sync_t s_reg;
   eqfcb_sync_t s_next;

   // The first stage feeds only the second one.
   always_comb begin
      s_next.meta = 1'b1;
      s_next.rel = s_reg.meta;
   end

   // Assert at once, release after two edges.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rst_n = s_reg.rel;
endmodule

// ---- core/eqfcb_regmem.sv ----
/*
  Small register memory of five 16-bit words with registered read data.
  Assumes one write or read strobe per cycle from the bank decoder.
*/
`timescale 1ns/100ps
module eqfcb_regmem (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [2:0] wr_slot,
   input wire logic [15:0] wr_data,
   input wire logic [2:0] rd_slot,
   output logic [15:0] rd_data,
   output logic [79:0] all_words
);
   typedef struct packed {
      logic [4:0][15:0] word;
      logic [15:0] rd;
   } eqfcb_mem_t;
   eqfcb_mem_t m_reg;
   eqfcb_mem_t m_next;

   // Every word is stored whole, reserved bits included, so reads echo writes.
   always_comb begin
      m_next = m_reg;
      for (int i = 0; i < eqfcb_pkg::NUM_REGS; i++) begin
         if (wr_en && (wr_slot == 3'(i))) begin
            m_next.word[i] = wr_data;
         end
      end
      m_next.rd = eqfcb_pkg::UNMAPPED_READ;
      for (int i = 0; i < eqfcb_pkg::NUM_REGS; i++) begin
         if (rd_slot == 3'(i)) begin
            m_next.rd = m_reg.word[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         m_reg <= '0;
      end else begin
         m_reg <= m_next;
      end
   end

   assign rd_data = m_reg.rd;
   assign all_words = m_reg.word;
endmodule

// ---- core/eqfcb_bank.sv ----
/*
  Coefficient bank for the nine-tap equalizer: channel A tap eight and
  channel B taps zero to three, with the taps fanned out to the filters.
  Assumes a register master that issues one-cycle strobes and takes read
  data in the cycle after a read strobe.
*/
`timescale 1ns/100ps
module eqfcb_bank (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [11:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic dual_mode,
   output logic signed [11:0] chan_a_tap8,
   output logic signed [11:0] single_tap8,
   output logic signed [11:0] chan_b_tap0,
   output logic signed [11:0] chan_b_tap1,
   output logic signed [11:0] chan_b_tap2,
   output logic signed [11:0] chan_b_tap3,
   output logic signed [17:0] centre_tap_unused
);
   typedef struct packed {
      logic mode_s1;
      logic mode_s2;
      logic [11:0] a8;
      logic [11:0] s8;
      logic [11:0] b0;
      logic [11:0] b1;
      logic [11:0] b2;
      logic [11:0] b3;
      logic [17:0] centre;
   } eqfcb_state_t;

   logic rst_n;
   logic [15:0] mem_rd;
   logic [79:0] words;
   logic [2:0] wr_slot;
   logic [2:0] rd_slot;
   eqfcb_state_t st_reg;
   eqfcb_state_t st_next;

   // Decode a printed offset into a slot; used for both strobes.
   function automatic logic [2:0] slot_of(input logic [11:0] a);
      logic [2:0] s;
      s = eqfcb_pkg::SLOT_NONE;
      unique case (a)
         eqfcb_pkg::CHAN_A_TAP8_COEF_OFF: s = eqfcb_pkg::SLOT_A8;
         eqfcb_pkg::CHAN_B_TAP0_COEF_OFF: s = eqfcb_pkg::SLOT_B0;
         eqfcb_pkg::CHAN_B_TAP1_COEF_OFF: s = eqfcb_pkg::SLOT_B1;
         eqfcb_pkg::CHAN_B_TAP2_COEF_OFF: s = eqfcb_pkg::SLOT_B2;
         eqfcb_pkg::CHAN_B_TAP3_COEF_OFF: s = eqfcb_pkg::SLOT_B3;
         default: s = eqfcb_pkg::SLOT_NONE;
      endcase
      return s;
   endfunction

   // Low field of a stored word, read as a signed coefficient.
   function automatic logic [11:0] coef_of(input logic [15:0] w);
      return w[eqfcb_pkg::OUTER_COEF_MSB:0];
   endfunction

   eqfcb_sync u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .rst_n(rst_n)
   );

   // Unmapped offsets write nothing and read as zero.
   assign wr_slot = reg_wr ? slot_of(reg_addr) : eqfcb_pkg::SLOT_NONE;
   assign rd_slot = reg_rd ? slot_of(reg_addr) : eqfcb_pkg::SLOT_NONE;

   eqfcb_regmem u_mem (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(reg_wr),
      .wr_slot(wr_slot),
      .wr_data(reg_wdata),
      .rd_slot(rd_slot),
      .rd_data(mem_rd),
      .all_words(words)
   );

   // Tap fan-out; the mode pin is synchronised since it is a static strap.
   always_comb begin
      st_next = st_reg;
      st_next.mode_s1 = dual_mode;
      st_next.mode_s2 = st_reg.mode_s1;
      st_next.a8 = st_reg.mode_s2 ? coef_of(words[15:0]) : '0;
      st_next.s8 = st_reg.mode_s2 ? '0 : coef_of(words[15:0]);
      st_next.b0 = st_reg.mode_s2 ? coef_of(words[31:16]) : '0;
      st_next.b1 = st_reg.mode_s2 ? coef_of(words[47:32]) : '0;
      st_next.b2 = st_reg.mode_s2 ? coef_of(words[63:48]) : '0;
      st_next.b3 = st_reg.mode_s2 ? coef_of(words[79:64]) : '0;
      st_next.centre = '0;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // The read word already leaves a flip-flop inside the memory.
   assign reg_rdata = mem_rd;
   assign chan_a_tap8 = st_reg.a8;
   assign single_tap8 = st_reg.s8;
   assign chan_b_tap0 = st_reg.b0;
   assign chan_b_tap1 = st_reg.b1;
   assign chan_b_tap2 = st_reg.b2;
   assign chan_b_tap3 = st_reg.b3;
   assign centre_tap_unused = st_reg.centre;
endmodule

// ---- bench/eqfcb_assertions.sv ----
/* Port checker for the coefficient bank.
   Assumes it is bound to eqfcb_bank and sees only its ports. */
`timescale 1ns/100ps
module eqfcb_assertions (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [11:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic dual_mode,
   input wire logic signed [11:0] chan_a_tap8,
   input wire logic signed [11:0] single_tap8,
   input wire logic signed [11:0] chan_b_tap0,
   input wire logic signed [11:0] chan_b_tap1,
   input wire logic signed [11:0] chan_b_tap2,
   input wire logic signed [11:0] chan_b_tap3,
   input wire logic signed [17:0] centre_tap_unused
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // High when the port addresses one of the five registers.
   wire mp = reg_addr inside {12'h429, 12'h448, 12'h44A, 12'h44C, 12'h44E};
   // Mode is pinned at both ends of its settling path, so a change cannot race the write.
   property tp(o, t, m);
      reg_wr && reg_addr == o && dual_mode == m && $past(dual_mode, 4) == m
      |-> ##2 t == $past(reg_wdata[11:0], 2);
   endproperty
   a8_dual_a: assert property (tp(12'h429, chan_a_tap8, 1'b1)) else $error("a8 dual");
   a8_single_a: assert property (tp(12'h429, single_tap8, 1'b0)) else $error("a8 single");
   b0_tap_a: assert property (tp(12'h448, chan_b_tap0, 1'b1)) else $error("b0 tap");
   b1_tap_a: assert property (tp(12'h44A, chan_b_tap1, 1'b1)) else $error("b1 tap");
   b2_tap_a: assert property (tp(12'h44C, chan_b_tap2, 1'b1)) else $error("b2 tap");
   b3_tap_a: assert property (tp(12'h44E, chan_b_tap3, 1'b1)) else $error("b3 tap");
   read_back_a: assert property (reg_wr && mp ##2 reg_rd && reg_addr == $past(reg_addr, 2)
      |=> reg_rdata == $past(reg_wdata, 3)) else $error("read back");
   idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0) else $error("idle");
   unmapped_a: assert property (reg_rd && !mp |=> reg_rdata == 16'h0) else $error("unmapped");
   b_quiet_a: assert property (!dual_mode [*5] |-> chan_b_tap0 == 12'h0) else $error("b quiet");
   s_quiet_a: assert property (dual_mode [*5] |-> single_tap8 == 12'h0) else $error("s quiet");
   centre_zero_a: assert property (centre_tap_unused == 18'h0) else $error("centre");
   cover property (reg_wr && mp && !dual_mode);
   cover property (reg_rd && mp);
   cover property (reg_rd && !mp);
endmodule

// ---- bench/fir_equalizer_coef_bank_bench.sv ----
/* Bench for the coefficient bank: register access and tap fan-out.
   Assumes one clock and a slave that never stalls. */
`timescale 1ns/100ps
module fir_equalizer_coef_bank_bench;
   logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, dual_mode = 1;
   logic [11:0] reg_addr = 0;
   logic [15:0] reg_wdata = 0, reg_rdata;
   logic signed [11:0] a8, s8, b0, b1, b2, b3;
   logic signed [17:0] ct;
   int n_mismatch = 0, check_count = 0, cyc = 0;
   logic [11:0] o[5] = '{12'h429, 12'h448, 12'h44A, 12'h44C, 12'h44E};
   // Extremes of the signed field, with reserved bits set in some words.
   logic [15:0] v[5] = '{16'hF800, 16'h07FF, 16'hA801, 16'h5FFF, 16'h3123};
   eqfcb_bank uut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dual_mode(dual_mode),
      .chan_a_tap8(a8), .single_tap8(s8), .chan_b_tap0(b0), .chan_b_tap1(b1),
      .chan_b_tap2(b2), .chan_b_tap3(b3), .centre_tap_unused(ct));
   // Clock and a hang guard well above the expected run length.
   initial forever #2 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         results;
      end
   end
   task chk(logic [17:0] g, e);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(logic [11:0] a, logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask
   // Read data stand only in the cycle after the strobe, so look just past that edge.
   task rd(logic [11:0] a, logic [15:0] e);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 chk(reg_rdata, e);
   endtask
   task t_reset;
      for (int i = 0; i < 5; i++) rd(o[i], 16'h0);
      rd(12'h42A, 16'h0);
   endtask
   task t_dual;
      for (int i = 0; i < 5; i++) wr(o[i], v[i]);
      wr(12'h44B, 16'hFFFF);
      for (int i = 0; i < 5; i++) rd(o[i], v[i]);
      rd(12'h44B, 16'h0);
      chk(a8, $signed(v[0][11:0]));
      chk(b0, $signed(v[1][11:0]));
      chk(b1, $signed(v[2][11:0]));
      chk(b2, $signed(v[3][11:0]));
      chk(b3, $signed(v[4][11:0]));
      chk(s8, 18'h0);
      chk(ct, 18'h0);
   endtask
   task t_single;
      @(posedge clk);
      dual_mode <= 1'h0;
      repeat (5) @(posedge clk);
      #1 chk(s8, $signed(v[0][11:0]));
      chk(b3, 18'h0);
      wr(o[0], 16'h0123);
      rd(o[0], 16'h0123);
      chk(s8, 18'h123);
      chk(a8, 18'h0);
   endtask
   task results;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'h1;
      repeat (4) @(posedge clk);
      t_reset;
      t_dual;
      t_single;
      results;
   end
endmodule
bind eqfcb_bank eqfcb_assertions chk (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .dual_mode(dual_mode), .chan_a_tap8(chan_a_tap8), .single_tap8(single_tap8),
   .chan_b_tap0(chan_b_tap0), .chan_b_tap1(chan_b_tap1), .chan_b_tap2(chan_b_tap2),
   .chan_b_tap3(chan_b_tap3), .centre_tap_unused(centre_tap_unused));
